// >>> core/usb_global_ctrl_regs.sv
// USB global interrupt enable, function address and endpoint select registers
`timescale 1ns/1ps
module usb_global_ctrl_regs (
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   // Avalon-MM slave
   input wire logic [usb_global_ctrl_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [usb_global_ctrl_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [usb_global_ctrl_pkg::DATA_W-1:0] O_AVS_READDATA,
   output logic [1:0] O_AVS_RESPONSE,
   output logic O_AVS_WAITREQUEST,
   // Global event flags from the flag register
   input wire logic I_WAKE_FLAG,
   input wire logic I_BUS_RESET_END_FLAG,
   input wire logic I_FRAME_START_FLAG,
   input wire logic I_SUSPEND_FLAG,
   input wire logic I_ADDR_VALID_FLAG,
   // USB side
   input wire logic I_USB_BUS_RESET,
   input wire logic I_TOKEN_VALID,
   input wire logic [6:0] I_TOKEN_ADDR,
   // Outputs to the USB engine and CPU
   output logic O_USB_IRQ,
   output logic O_ADDR_FILTER_ON,
   output logic [6:0] O_FUNCTION_ADDR,
   output logic [3:0] O_ENDPOINT_SEL,
   output logic O_TOKEN_ACCEPT
);
   logic ack_r;
   logic [7:0] irq_en_r;
   logic [7:0] irq_en_nxt;
   logic [7:0] faddr_r;
   logic [7:0] faddr_nxt;
   logic [7:0] ep_sel_r;
   logic [7:0] ep_sel_nxt;
   logic [31:0] rdata_r;
   logic [1:0] resp_r;
   logic irq_r;
   logic [6:0] eff_addr_r;
   logic accept_r;

   wire req = I_AVS_READ | I_AVS_WRITE;
   wire aligned = (I_AVS_ADDRESS[1:0] == 2'h0);
   wire [7:0] word_idx = I_AVS_ADDRESS[9:2];
   wire hit_en = aligned && (word_idx == usb_global_ctrl_pkg::IDX_IRQ_ENABLE);
   wire hit_fa = aligned && (word_idx == usb_global_ctrl_pkg::IDX_FUNCTION_ADDRESS);
   wire hit_ep = aligned && (word_idx == usb_global_ctrl_pkg::IDX_ENDPOINT_SELECT);
   wire mapped = hit_en | hit_fa | hit_ep;
   // Write lands only at the edge where waitrequest is low
   wire wr_take = I_AVS_WRITE & ack_r & I_AVS_BYTEENABLE[0];
   wire [7:0] wbyte = I_AVS_WRITEDATA[7:0];

   // One wait state per access gives a registered read path
   assign O_AVS_WAITREQUEST = req & ~ack_r;
   assign O_AVS_READDATA = rdata_r;
   assign O_AVS_RESPONSE = resp_r;

   // Reserved bits are masked off on write so they can never read back as one
   assign irq_en_nxt = (hit_en & wr_take) ?
      (wbyte & usb_global_ctrl_pkg::IRQ_ENABLE_MASK) : irq_en_r;
   // Bus reset wins over a CPU write in the same cycle
   assign faddr_nxt = I_USB_BUS_RESET ? {faddr_r[7], usb_global_ctrl_pkg::DEFAULT_FUNCTION_ADDR} :
      (hit_fa & wr_take) ? (wbyte & usb_global_ctrl_pkg::FUNCTION_ADDRESS_MASK) :
      faddr_r;
   // Values 7 to 15 are stored as written; software keeps to 0..6
   assign ep_sel_nxt = (hit_ep & wr_take) ?
      (wbyte & usb_global_ctrl_pkg::ENDPOINT_SELECT_MASK) : ep_sel_r;

   wire [7:0] rd_byte = hit_en ? irq_en_r : hit_fa ? faddr_r : hit_ep ? ep_sel_r : 8'h00;

   // Each flag is gated by its enable bit
   wire [7:0] flag_vec = {2'h0, I_WAKE_FLAG, I_BUS_RESET_END_FLAG, I_FRAME_START_FLAG,
      2'h0, I_SUSPEND_FLAG};
   wire [7:0] gated = flag_vec & irq_en_r;
   wire irq_nxt = |gated;

   wire [6:0] eff_addr_nxt = I_ADDR_VALID_FLAG ? faddr_r[6:0] :
      usb_global_ctrl_pkg::DEFAULT_FUNCTION_ADDR;
   wire filter_on = faddr_r[usb_global_ctrl_pkg::ADDR_FILTER_ON_BIT];
   wire accept_nxt = I_TOKEN_VALID & (~filter_on | (I_TOKEN_ADDR == eff_addr_nxt));

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         resp_r <= usb_global_ctrl_pkg::RESP_OKAY;
      end else begin
         ack_r <= req & ~ack_r;
         if (req & ~ack_r) begin
            rdata_r <= {24'h00_0000, rd_byte};
            resp_r <= mapped ? usb_global_ctrl_pkg::RESP_OKAY : usb_global_ctrl_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         irq_en_r <= usb_global_ctrl_pkg::IRQ_ENABLE_RESET;
         faddr_r <= usb_global_ctrl_pkg::FUNCTION_ADDRESS_RESET;
         ep_sel_r <= usb_global_ctrl_pkg::ENDPOINT_SELECT_RESET;
      end else begin
         irq_en_r <= irq_en_nxt;
         faddr_r <= faddr_nxt;
         ep_sel_r <= ep_sel_nxt;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         irq_r <= 1'b0;
         eff_addr_r <= usb_global_ctrl_pkg::DEFAULT_FUNCTION_ADDR;
         accept_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
         eff_addr_r <= eff_addr_nxt;
         accept_r <= accept_nxt;
      end
   end

   assign O_USB_IRQ = irq_r;
   assign O_ADDR_FILTER_ON = filter_on;
   assign O_FUNCTION_ADDR = eff_addr_r;
   assign O_ENDPOINT_SEL = ep_sel_r[3:0];
   assign O_TOKEN_ACCEPT = accept_r;

   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_RESET);

   irq_en_reset_a: assert property ($fell(I_RESET) |-> irq_en_r == 8'h10)
      else $error("interrupt enable not 10h after reset");
   wake_gate_a: assert property (I_WAKE_FLAG && irq_en_r[5] |=> O_USB_IRQ)
      else $error("enabled wake flag did not raise irq");
   frame_gate_a: assert property (I_FRAME_START_FLAG && irq_en_r[3] |=> O_USB_IRQ)
      else $error("enabled frame flag did not raise irq");
   suspend_gate_a: assert property (I_SUSPEND_FLAG && irq_en_r[0] |=> O_USB_IRQ)
      else $error("enabled suspend flag did not raise irq");
   irq_masked_a: assert property ((gated == 8'h00) |=> !O_USB_IRQ)
      else $error("irq raised with no enabled flag");
   end_reset_gate_a: assert property (I_BUS_RESET_END_FLAG && irq_en_r[4] |=> O_USB_IRQ)
      else $error("enabled end of reset flag did not raise irq");
   reserved_zero_a: assert property ((irq_en_r & 8'hc6) == 8'h00
      && ep_sel_r[7:4] == 4'h0 && O_AVS_READDATA[31:8] == 24'h00_0000)
      else $error("reserved bit reads as one");
   readback_a: assert property (hit_fa && I_AVS_READ && !O_AVS_WAITREQUEST
      && !$past(I_USB_BUS_RESET) |-> O_AVS_READDATA[7:0] == faddr_r)
      else $error("address register readback mismatch");
   filter_bit_a: assert property (hit_fa && wr_take && !I_USB_BUS_RESET
      |=> O_ADDR_FILTER_ON == $past(I_AVS_WRITEDATA[7]))
      else $error("filter bit did not follow write");
   bus_reset_clear_a: assert property (I_USB_BUS_RESET |=> faddr_r[6:0] == 7'h00)
      else $error("address field not cleared by bus reset");
   ep_select_a: assert property (hit_ep && wr_take
      |=> O_ENDPOINT_SEL == $past(I_AVS_WRITEDATA[3:0]))
      else $error("endpoint selector did not follow write");
   default_addr_a: assert property (!I_ADDR_VALID_FLAG |=> O_FUNCTION_ADDR == 7'h00)
      else $error("nonzero address while address not valid");
   token_filter_a: assert property (I_TOKEN_VALID && filter_on
      && I_TOKEN_ADDR != eff_addr_nxt |=> !O_TOKEN_ACCEPT)
      else $error("foreign token accepted with filtering on");
   wait_one_a: assert property (O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
      else $error("access waited more than one cycle");

   // Bus side: a write that lands early would corrupt a register mid-access
   enable_write_a: assert property (hit_en && wr_take
      |=> irq_en_r == ($past(I_AVS_WRITEDATA[7:0]) & 8'h39))
      else $error("enable register did not take masked write");
   no_early_write_a: assert property (O_AVS_WAITREQUEST && !I_USB_BUS_RESET
      |=> $stable(faddr_r) && $stable(irq_en_r) && $stable(ep_sel_r))
      else $error("register changed while waitrequest high");
   lane_off_a: assert property (I_AVS_WRITE && !I_AVS_BYTEENABLE[0]
      && !I_USB_BUS_RESET |=> $stable(faddr_r) && $stable(irq_en_r) && $stable(ep_sel_r))
      else $error("write with lane 0 off changed a register");
   enable_read_a: assert property (hit_en && I_AVS_READ && !O_AVS_WAITREQUEST
      |-> O_AVS_READDATA[7:0] == irq_en_r)
      else $error("enable register readback mismatch");
   select_read_a: assert property (hit_ep && I_AVS_READ && !O_AVS_WAITREQUEST
      |-> O_AVS_READDATA[7:0] == ep_sel_r)
      else $error("selector readback mismatch");
   unmapped_a: assert property (O_AVS_WAITREQUEST && !mapped
      |=> O_AVS_RESPONSE == 2'h2 && O_AVS_READDATA == 32'h0000_0000)
      else $error("unmapped access not refused");
   mapped_okay_a: assert property (O_AVS_WAITREQUEST && mapped |=> O_AVS_RESPONSE == 2'h0)
      else $error("mapped access answered with error");

   // USB side: bus reset clears only the address field
   filter_kept_a: assert property (I_USB_BUS_RESET |=> faddr_r[7] == $past(faddr_r[7]))
      else $error("bus reset changed the filter bit");
   select_kept_a: assert property (I_USB_BUS_RESET && !wr_take
      |=> $stable(ep_sel_r) && $stable(irq_en_r))
      else $error("bus reset changed selector or enables");
   valid_addr_a: assert property (I_ADDR_VALID_FLAG
      |=> O_FUNCTION_ADDR == $past(faddr_r[6:0]))
      else $error("stored address not used while valid");
   token_match_a: assert property (I_TOKEN_VALID
      && (!filter_on || I_TOKEN_ADDR == eff_addr_nxt) |=> O_TOKEN_ACCEPT)
      else $error("matching token not accepted");
   accept_pulse_a: assert property (!I_TOKEN_VALID |=> !O_TOKEN_ACCEPT)
      else $error("accept without a token");

   irq_seen_c: cover property (I_WAKE_FLAG && irq_en_r[5] ##1 O_USB_IRQ);
   token_drop_c: cover property (I_TOKEN_VALID && filter_on ##1 !O_TOKEN_ACCEPT);
   bus_reset_c: cover property (faddr_r[6:0] != 7'h00 ##1 I_USB_BUS_RESET);
   unmapped_c: cover property (req && !mapped ##1 O_AVS_RESPONSE == 2'h2);
   lane_off_c: cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST && !I_AVS_BYTEENABLE[0]);
endmodule

// >>> shared/usb_global_ctrl_pkg.sv
// Constants for the USB global control register bank
package usb_global_ctrl_pkg;
   // Bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'hbe;
   localparam logic [7:0] IDX_FUNCTION_ADDRESS = 8'hc6;
   localparam logic [7:0] IDX_ENDPOINT_SELECT = 8'hc7;
   // Reset values and writable-bit masks
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h10;
   localparam logic [7:0] IRQ_ENABLE_MASK = 8'h39;
   localparam logic [7:0] FUNCTION_ADDRESS_RESET = 8'h00;
   localparam logic [7:0] FUNCTION_ADDRESS_MASK = 8'hff;
   localparam logic [7:0] ENDPOINT_SELECT_RESET = 8'h00;
   localparam logic [7:0] ENDPOINT_SELECT_MASK = 8'h0f;
   // Field positions
   localparam int WAKE_IRQ_EN_BIT = 5;
   localparam int BUS_RESET_END_IRQ_EN_BIT = 4;
   localparam int FRAME_START_IRQ_EN_BIT = 3;
   localparam int SUSPEND_IRQ_EN_BIT = 0;
   localparam int ADDR_FILTER_ON_BIT = 7;
   localparam int FUNCTION_ADDR_W = 7;
   localparam int ENDPOINT_SEL_W = 4;
   localparam logic [6:0] DEFAULT_FUNCTION_ADDR = 7'h00;
   // Avalon response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> tb/usb_global_ctrl_regs_tb.sv
// Self-checking bench for the USB global control register bank
`timescale 1ns/1ps
module usb_global_ctrl_regs_tb;
   localparam logic [9:0] A_EN = {usb_global_ctrl_pkg::IDX_IRQ_ENABLE, 2'b00};
   localparam logic [9:0] A_FA = {usb_global_ctrl_pkg::IDX_FUNCTION_ADDRESS, 2'b00};
   localparam logic [9:0] A_EP = {usb_global_ctrl_pkg::IDX_ENDPOINT_SELECT, 2'b00};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic bus_rst = 1'b0;
   logic [9:0] adr = '0;
   logic [31:0] wd = '0;
   logic [3:0] be = 4'hf;
   logic [4:0] flg = '0;
   logic [31:0] rdat, got;
   logic [1:0] resp, got_resp;
   logic wait_q, tv, irq, filt, acc, ok;
   logic [6:0] ta, fa;
   logic [3:0] eps;
   int error_cnt = 0;
   int n_checks = 0;
   int pos[4] = '{5, 4, 3, 0};
   usb_global_ctrl_regs u_usb_global_ctrl_regs (.I_CLOCK(clk), .I_RESET(rst),
      .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
      .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat), .O_AVS_RESPONSE(resp),
      .O_AVS_WAITREQUEST(wait_q), .I_WAKE_FLAG(flg[3]), .I_BUS_RESET_END_FLAG(flg[2]),
      .I_FRAME_START_FLAG(flg[1]), .I_SUSPEND_FLAG(flg[0]), .I_ADDR_VALID_FLAG(flg[4]),
      .I_USB_BUS_RESET(bus_rst), .I_TOKEN_VALID(tv), .I_TOKEN_ADDR(ta), .O_USB_IRQ(irq),
      .O_ADDR_FILTER_ON(filt), .O_FUNCTION_ADDR(fa), .O_ENDPOINT_SEL(eps),
      .O_TOKEN_ACCEPT(acc));
   usb_host_model u_usb_host_model (.i_clk(clk), .i_accept(acc), .o_token_valid(tv),
      .o_token_addr(ta));
   initial forever #20 clk = ~clk;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {24'h00_0000, d};
      @(posedge clk);
      while (wait_q) @(posedge clk);
      got = rdat;
      got_resp = resp;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic t_reset();
      bus(0, A_EN, 0); chk("enable reset", 32'h0000_0010, got);
      chk("okay resp", 0, got_resp);
      bus(0, A_FA, 0); chk("address reset", 32'h0000_0000, got);
      bus(0, A_EP, 0); chk("select reset", 32'h0000_0000, got);
      $display("reset values done");
   endtask
   task automatic t_enables();
      bus(1, A_EN, 8'hff);
      bus(0, A_EN, 0); chk("enable reserved", 32'h0000_0039, got);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         flg[3:0] <= 4'b1000 >> i;
         bus(1, A_EN, 8'h39 & ~(8'h01 << pos[i]));
         repeat (2) @(negedge clk);
         chk("irq masked", 0, irq);
         bus(1, A_EN, 8'h01 << pos[i]);
         repeat (2) @(negedge clk);
         chk("irq enabled", 1, irq);
      end
      @(posedge clk);
      flg[3:0] <= 4'h0;
      $display("interrupt enables done");
   endtask
   task automatic t_address();
      flg[4] <= 1'b1;
      bus(1, A_FA, 8'h85);
      @(negedge clk); chk("filter on", 1, filt);
      u_usb_host_model.send(7'h05, ok); chk("match token", 1, ok);
      chk("effective addr", 5, fa);
      u_usb_host_model.send(7'h06, ok); chk("other token", 0, ok);
      @(posedge clk);
      flg[4] <= 1'b0;
      u_usb_host_model.send(7'h00, ok); chk("default addr", 1, ok);
      chk("default out", 0, fa);
      u_usb_host_model.send(7'h05, ok); chk("stored addr off", 0, ok);
      @(posedge clk) bus_rst <= 1'b1;
      @(posedge clk) bus_rst <= 1'b0;
      bus(0, A_FA, 0); chk("bus reset addr", 32'h0000_0080, got);
      bus(1, A_FA, 8'h05);
      u_usb_host_model.send(7'h06, ok); chk("filter off", 1, ok);
      $display("function address done");
   endtask
   task automatic t_select();
      bus(1, A_EP, 8'hf6);
      bus(0, A_EP, 0); chk("select read", 32'h0000_0006, got);
      @(negedge clk); chk("select out", 6, eps);
      @(posedge clk);
      be <= 4'he;
      bus(1, A_EP, 8'h03);
      be <= 4'hf;
      chk("lane off resp", 0, got_resp);
      bus(0, A_EP, 0); chk("lane off write", 32'h0000_0006, got);
      bus(0, A_EN + 10'h001, 0); chk("misaligned resp", 2, got_resp);
      bus(0, A_EN - 10'h004, 0); chk("unmapped resp", 2, got_resp);
      chk("unmapped data", 0, got);
      $display("selector and unmapped done");
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_enables();
      t_address();
      t_select();
      end_sim();
   end
   // Whole run needs about 100 cycles; the limit is 5000 cycles
   initial begin
      #(40 * 5000);
      error_cnt++;
      end_sim();
   end
endmodule

// >>> tb/usb_host_model.sv
// Host-side token source facing the register bank
`timescale 1ns/1ps
module usb_host_model (
   input wire logic i_clk,
   input wire logic i_accept,
   output logic o_token_valid,
   output logic [6:0] o_token_addr
);
   initial begin
      o_token_valid = 1'b0;
      o_token_addr = 7'h7f;
   end
   // One token per call; a released address line shows the inverse value
   task automatic send(input logic [6:0] a, output logic acc);
      @(posedge i_clk);
      o_token_valid <= 1'b1;
      o_token_addr <= a;
      @(posedge i_clk);
      o_token_valid <= 1'b0;
      o_token_addr <= ~a;
      @(negedge i_clk);
      acc = i_accept;
   endtask
endmodule
